// file: core/boie_core.sv
// Overview of operation
// [RL1] Clear opcode writes zero to the selected bit of the addressed register.
// [RL2] Set opcode writes one to the selected bit of the addressed register.
// [RL3] Test-skip opcode decodes bit index after opcode, address in low five bits.
// [RL4] Test-skip skips next instruction when selected bit is zero.
// [RL5] A taken skip discards the prefetched word and executes a no-operation.
// [RL6] Test-skip takes one cycle, or two when the skip is taken; one word.
// [RL7] None of these instructions alter arithmetic status flags.
// [RL8] Instruction is 12 bits: opcode top four, bit index three, address five.
`timescale 1ns/1ps
`default_nettype none
module boie_core
(
   input  wire logic                          clk,
   input  wire logic                          nrst,
   input  wire logic [boie_pkg::INSTR_W-1:0]  instr,
   input  wire logic                          instr_valid,
   output var  logic [boie_pkg::INSTR_W-1:0]  exec_instr,
   output var  logic                          exec_squashed,
   output var  logic                          skip_taken,
   output var  logic [boie_pkg::DATA_W-1:0]   reg_rd_data,
   output var  logic                          status_write
);
   import boie_pkg::*;

   // ========================================================================
   // Decode
   logic [DATA_W-1:0] file_regs [NREGS];
   logic [3:0]        opc;
   logic [2:0]        bsel;
   logic [ADDR_W-1:0] faddr;
   boie_op_t          op;
   logic              squash;
   logic              tested_bit;
   logic [DATA_W-1:0] bit_mask;

   // Field split of the 12-bit word
   assign opc   = instr[OPC_HI:OPC_LO];     // [RL8]
   assign bsel  = instr[BIT_HI:BIT_LO];     // [RL3]
   assign faddr = instr[ADDR_HI:ADDR_LO];   // [RL3]

   // Opcode classification; a squashed slot decodes as nothing
   always_comb begin
      op = BOIE_NONE;
      if (instr_valid && !squash) begin
         case (opc)
            OPC_CLEAR:    op = BOIE_CLEAR;
            OPC_SET:      op = BOIE_SET;
            OPC_TEST_CLR: op = BOIE_TEST;   // [RL3]
            default:      op = BOIE_NONE;
         endcase
      end
   end

   // Selected bit of the addressed register, read by the test
   assign tested_bit = file_regs[faddr][bsel];

   // One-hot mask of the selected bit, used by the checks
   assign bit_mask = DATA_W'(1) << bsel;

   // ========================================================================
   // File register array with bit writes
   generate
      for (genvar r = 0; r < NREGS; r++) begin : g_reg
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               file_regs[r] <= REG_RESET;
            end else if (faddr == ADDR_W'(r)) begin
               if (op == BOIE_CLEAR) begin
                  file_regs[r][bsel] <= 1'b0;   // [RL1]
               end else if (op == BOIE_SET) begin
                  file_regs[r][bsel] <= 1'b1;   // [RL2]
               end
            end
         end
      end
   endgenerate

   // ========================================================================
   // Skip control: the next slot becomes a no-operation
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         squash <= 1'b0;
      end else if (instr_valid) begin
         squash <= (op == BOIE_TEST) && !tested_bit;   // [RL4] [RL6]
      end
   end

   // Executed word and observation outputs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         exec_instr    <= INSTR_NOP;
         exec_squashed <= 1'b0;
         skip_taken    <= 1'b0;
         reg_rd_data   <= REG_RESET;
      end else begin
         exec_instr    <= (instr_valid && !squash) ? instr : INSTR_NOP;   // [RL5]
         exec_squashed <= instr_valid && squash;                          // [RL5]
         skip_taken    <= instr_valid && (op == BOIE_TEST) && !tested_bit;   // [RL4]
         reg_rd_data   <= file_regs[faddr];
      end
   end

   // No status flag path exists in this block
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_write <= 1'b0;
      end else begin
         status_write <= 1'b0;   // [RL7]
      end
   end

   // ========================================================================
   // Checks
   property p_clear_bit;
      @(posedge clk) disable iff (!nrst)
      (op == BOIE_CLEAR) |=> (file_regs[$past(faddr)][$past(bsel)] == 1'b0);
   endproperty
   a_clear_bit: assert property (p_clear_bit) else $error("bit not cleared"); // [RL1]

   property p_set_bit;
      @(posedge clk) disable iff (!nrst)
      (op == BOIE_SET) |=> (file_regs[$past(faddr)][$past(bsel)] == 1'b1);
   endproperty
   a_set_bit: assert property (p_set_bit) else $error("bit not set"); // [RL2]

   property p_decode_test;
      @(posedge clk) disable iff (!nrst)
      (instr_valid && !squash && opc == OPC_TEST_CLR) |-> (op == BOIE_TEST);
   endproperty
   a_decode_test: assert property (p_decode_test) else $error("test op missed"); // [RL3]

   property p_skip_when_clear;
      @(posedge clk) disable iff (!nrst)
      (op == BOIE_TEST && !tested_bit) |=> squash;
   endproperty
   a_skip_when_clear: assert property (p_skip_when_clear) else $error("no skip"); // [RL4]

   property p_noskip_when_set;
      @(posedge clk) disable iff (!nrst)
      (instr_valid && op == BOIE_TEST && tested_bit) |=> !squash;
   endproperty
   a_noskip_when_set: assert property (p_noskip_when_set) else $error("false skip"); // [RL6]

   property p_squash_nop;
      @(posedge clk) disable iff (!nrst)
      (instr_valid && squash) |=> (exec_instr == INSTR_NOP && exec_squashed);
   endproperty
   a_squash_nop: assert property (p_squash_nop) else $error("slot not squashed"); // [RL5]

   property p_no_flags;
      @(posedge clk) disable iff (!nrst)
      !status_write;
   endproperty
   a_no_flags: assert property (p_no_flags) else $error("status touched"); // [RL7]

   property p_squash_no_write;
      @(posedge clk) disable iff (!nrst)
      (instr_valid && squash) |=> (file_regs[$past(faddr)] == $past(file_regs[faddr]));
   endproperty
   a_squash_no_write: assert property (p_squash_no_write) else $error("squashed write"); // [RL5]

   // ========================================================================
   // Checks on neighbouring bits, skip flag and slot flow
   // Clear moves only the selected bit
   property p_clear_exact;
      @(posedge clk) disable iff (!nrst)
      (op == BOIE_CLEAR) |=>
         (file_regs[$past(faddr)] == ($past(file_regs[faddr]) & ~$past(bit_mask)));
   endproperty
   a_clear_exact: assert property (p_clear_exact) else $error("clear hit others"); // [RL1]

   // Set moves only the selected bit
   property p_set_exact;
      @(posedge clk) disable iff (!nrst)
      (op == BOIE_SET) |=>
         (file_regs[$past(faddr)] == ($past(file_regs[faddr]) | $past(bit_mask)));
   endproperty
   a_set_exact: assert property (p_set_exact) else $error("set hit other bits"); // [RL2]

   // A test only reads its register
   property p_test_no_write;
      @(posedge clk) disable iff (!nrst)
      (op == BOIE_TEST) |=> (file_regs[$past(faddr)] == $past(file_regs[faddr]));
   endproperty
   a_test_no_write: assert property (p_test_no_write) else $error("test wrote"); // [RL4]

   // Ignored or squashed slots leave the array alone
   property p_none_no_write;
      @(posedge clk) disable iff (!nrst)
      (op == BOIE_NONE) |=> (file_regs[$past(faddr)] == $past(file_regs[faddr]));
   endproperty
   a_none_no_write: assert property (p_none_no_write) else $error("idle wrote"); // [RL5]

   // Skip flag follows a zero test bit
   property p_skip_flag;
      @(posedge clk) disable iff (!nrst)
      (op == BOIE_TEST && !tested_bit) |=> skip_taken;
   endproperty
   a_skip_flag: assert property (p_skip_flag) else $error("skip flag missing"); // [RL4]

   // No skip flag without a test
   property p_skip_flag_quiet;
      @(posedge clk) disable iff (!nrst)
      (op != BOIE_TEST) |=> !skip_taken;
   endproperty
   a_skip_flag_quiet: assert property (p_skip_flag_quiet) else $error("stray skip"); // [RL4]

   // A live slot executes its own word
   property p_pass_through;
      @(posedge clk) disable iff (!nrst)
      (instr_valid && !squash) |=> (exec_instr == $past(instr) && !exec_squashed);
   endproperty
   a_pass_through: assert property (p_pass_through) else $error("word not passed"); // [RL5]

   // A skip swallows exactly one valid word
   property p_squash_one_slot;
      @(posedge clk) disable iff (!nrst)
      (instr_valid && squash) |=> !squash;
   endproperty
   a_squash_one_slot: assert property (p_squash_one_slot) else $error("squash stuck"); // [RL6]

   // Without a skip the next valid word runs at once
   property p_noskip_next_runs;
      @(posedge clk) disable iff (!nrst)
      (op == BOIE_TEST && tested_bit) ##1 instr_valid |=> (exec_instr == $past(instr));
   endproperty
   a_noskip_next_runs: assert property (p_noskip_next_runs) else $error("word lost"); // [RL6]
endmodule
`default_nettype wire

// file: core/boie_pkg.sv
// ==========================================================================
// Instruction field layout and opcode patterns
`default_nettype none
package boie_pkg;
   localparam int unsigned INSTR_W      = 12;
   localparam int unsigned OPC_HI       = 11;
   localparam int unsigned OPC_LO       = 8;
   localparam int unsigned BIT_HI       = 7;
   localparam int unsigned BIT_LO       = 5;
   localparam int unsigned ADDR_HI      = 4;
   localparam int unsigned ADDR_LO      = 0;
   localparam int unsigned ADDR_W       = 5;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned NREGS        = 32;
   localparam logic [3:0]  OPC_CLEAR    = 4'h4;
   localparam logic [3:0]  OPC_SET      = 4'h5;
   localparam logic [3:0]  OPC_TEST_CLR = 4'h6;
   localparam logic [11:0] INSTR_NOP    = 12'h000;
   localparam logic [7:0]  REG_RESET    = 8'h00;
   typedef enum logic [1:0] {
      BOIE_NONE,
      BOIE_CLEAR,
      BOIE_SET,
      BOIE_TEST
   } boie_op_t;
endpackage
`default_nettype wire

// file: tb/boie_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module boie_core_tb;
   import boie_pkg::*;
   logic               clk;
   logic               nrst;
   logic [INSTR_W-1:0] instr;
   logic               instr_valid;
   logic [INSTR_W-1:0] exec_instr;
   logic               exec_squashed;
   logic               skip_taken;
   logic [DATA_W-1:0]  reg_rd_data;
   logic               status_write;
   int                 errors = 0;
   int                 num_checks = 0;
   boie_core dut (.clk(clk), .nrst(nrst), .instr(instr), .instr_valid(instr_valid),
      .exec_instr(exec_instr), .exec_squashed(exec_squashed), .skip_taken(skip_taken),
      .reg_rd_data(reg_rd_data), .status_write(status_write));
   // ======================================
   // Helpers
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Expected word: executed, skip, squash, read data, status write
   function automatic logic [22:0] e(logic [11:0] ex, logic sk, logic sq, logic [7:0] rd);
      return {ex, sk, sq, rd, 1'b0};
   endfunction
   task automatic chk(input logic [22:0] exp);
      num_checks++;
      if ({exec_instr, skip_taken, exec_squashed, reg_rd_data, status_write} !== exp) begin
         errors++;
         $display("[ERR] %0t outputs differ, expected %h", $time, exp);
      end
   endtask
   // Present one word; outputs then show the previous word
   task automatic step(input logic [11:0] w, input logic v);
      @(posedge clk);
      instr <= w;
      instr_valid <= v;
      #1;
   endtask
   task automatic test_done;
      if (errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ======================================
   // Scenarios
   task automatic t_set_clear;
      step(12'h5E5, 1'b1);
      step(12'h525, 1'b1);
      chk(e(12'h5E5, 1'b0, 1'b0, 8'h00));
      step(12'h4E5, 1'b1);
      chk(e(12'h525, 1'b0, 1'b0, 8'h80));
      step(12'h625, 1'b1);
      chk(e(12'h4E5, 1'b0, 1'b0, 8'h82));
   endtask
   task automatic t_no_skip;
      step(12'h5FF, 1'b1);
      chk(e(12'h625, 1'b0, 1'b0, 8'h02));
      step(12'h01F, 1'b1);
      chk(e(12'h5FF, 1'b0, 1'b0, 8'h00));
      step(12'h000, 1'b0);
      chk(e(12'h01F, 1'b0, 1'b0, 8'h80));
   endtask
   task automatic t_skip;
      step(12'h6E5, 1'b1);
      step(12'h5E5, 1'b1);
      chk(e(12'h6E5, 1'b1, 1'b0, 8'h02));
      step(12'h605, 1'b1);
      chk(e(12'h000, 1'b0, 1'b1, 8'h02));
      step(12'h000, 1'b0);
      chk(e(12'h605, 1'b1, 1'b0, 8'h02));
      step(12'h000, 1'b0);
      step(12'h5E5, 1'b1);
      step(12'h6E5, 1'b1);
      chk(e(12'h000, 1'b0, 1'b1, 8'h02));
      step(12'h000, 1'b0);
      chk(e(12'h6E5, 1'b1, 1'b0, 8'h02));
   endtask
   // Reset in mid-run clears outputs, drops a pending skip, clears the array
   task automatic t_reset_mid;
      @(posedge clk);
      nrst <= 1'b0;
      instr <= 12'h5E5;
      instr_valid <= 1'b1;
      @(posedge clk);
      #1;
      chk(e(12'h000, 1'b0, 1'b0, 8'h00));
      @(posedge clk);
      nrst <= 1'b1;
      instr_valid <= 1'b0;
      step(12'h5E5, 1'b1);
      step(12'h625, 1'b1);
      chk(e(12'h5E5, 1'b0, 1'b0, 8'h00));
      step(12'h000, 1'b0);
      chk(e(12'h625, 1'b1, 1'b0, 8'h80));
   endtask
   // Watchdog
   initial begin
      #5000;
      errors++;
      test_done();
   end
   // Main sequence
   initial begin
      nrst = 1'b0;
      instr = 12'h000;
      instr_valid = 1'b0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_set_clear();
      t_no_skip();
      t_skip();
      t_reset_mid();
      test_done();
   end
endmodule
`default_nettype wire
